// File: verilog/pc_irq_params.svh
`ifndef PC_IRQ_PARAMS_SVH
`define PC_IRQ_PARAMS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define EXCA_FUNC_SEL_OFS 8'h03
`define EXCA_FLAGS_OFS 8'h04
`define EXCA_MASK_OFS 8'h05
`define EXCA_GLOBAL_OFS 8'h1E
`define EXCA_SOCKET_BIT 6
`define CFG_SYSCTL_OFS 8'h80
`define CFG_MFROUTE_OFS 8'h8C
`define CFG_CARDCTL_OFS 8'h91
`define CFG_DEVCTL_OFS 8'h92
`define SKT_EVENT_OFS 8'h00
`define SKT_MASK_OFS 8'h04

// ********************************************************************
// Field positions
// ********************************************************************
`define FLAG_BATT_ONE 0
`define FLAG_CARD_STATUS_CHANGE_LINE 0
`define FLAG_BATT_TWO 1
`define FLAG_READY 2
`define FLAG_POWER 3
`define EVENT_CARD_STATUS_CHANGE_LINE 0
`define EVENT_DETECT_ONE 1
`define EVENT_DETECT_TWO 2
`define EVENT_POWER 3
`define GLOBAL_SIGNAL_MODE_BIT 1
`define GLOBAL_CLEAR_METHOD_BIT 2
`define SYSCTL_TIE_BIT 29
`define DEVCTL_SCHEME_HI 2
`define DEVCTL_SCHEME_LO 1
`define DEVCTL_SCHEME_PARALLEL 2'h2
`define CARDCTL_FUNC_BIT 0
`define MF_FIELD_W 4
`define MF_COUNT 7
`define MF_CODE_PCI_INT 4'h2
`define MF_CODE_FIRST_IRQ 4'h3
`define PIN_PER_SOCKET 5

// ********************************************************************
// Reset values
// ********************************************************************
`define RESET_BYTE 8'h00
`define RESET_NIBBLE 4'h0
`define RESET_ROUTE 28'h0000000

`endif

// File: verilog/pc_irq_pkg.sv
package pc_irq_pkg;

  // ******************************************************************
  // Register spaces
  // ******************************************************************
  typedef enum logic [1:0] {
    space_config,
    space_exca,
    space_socket
  } reg_space_type;

endpackage : pc_irq_pkg

// File: verilog/pin_watch.sv
`timescale 1ns/1ps
module pin_watch #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw pins
  input wire logic [W-1:0] pin,
  // Synchronised view
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] toggle
);

  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] last_q;

  // The first stage feeds only the second, so metastability stays put.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      last_q <= '0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  assign level = sync2_q;
  assign rise = sync2_q & ~last_q;
  assign toggle = sync2_q ^ last_q;

endmodule : pin_watch

// File: verilog/flag_bank.sv
`timescale 1ns/1ps
module flag_bank #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Events and clears
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clear,
  // Sticky flags
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // A set in the clearing cycle wins, so no event is ever lost.
  assign flags_d = set | (flags_q & ~clear);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule : flag_bank

// File: verilog/pc_card_irq.sv
`timescale 1ns/1ps
`include "pc_irq_params.svh"

module pc_card_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register access port
  input wire pc_irq_pkg::reg_space_type reg_space,
  input wire logic reg_func,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Socket pins, one bit per socket, active high
  input wire logic [1:0] battery_detect_one,
  input wire logic [1:0] battery_detect_two,
  input wire logic [1:0] io_card_request_line,
  input wire logic [1:0] card_detect_one,
  input wire logic [1:0] card_detect_two,
  // Card state from socket control logic
  input wire logic [1:0] memory_card,
  input wire logic [1:0] cardbus_card,
  input wire logic [1:0] power_up_done,
  // Multifunction terminals
  output logic [6:0] multifunction_terminals_out,
  output logic [6:0] multifunction_terminals_oe
);

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [9:0] pin_raw, pin_level, pin_rise, pin_toggle;
  assign pin_raw = {card_detect_two[1], card_detect_one[1],
                    io_card_request_line[1], battery_detect_two[1],
                    battery_detect_one[1], card_detect_two[0],
                    card_detect_one[0], io_card_request_line[0],
                    battery_detect_two[0], battery_detect_one[0]};

  pin_watch #(.W(10)) u_pins (
    .clk(clk), .nrst(nrst), .pin(pin_raw),
    .level(pin_level), .rise(pin_rise), .toggle(pin_toggle)
  );

  // ******************************************************************
  // Register decode
  // ******************************************************************
  logic exca_hit, cfg_hit, skt_hit, exca_sock, parallel_mode;
  logic [7:0] exca_ofs;

  assign exca_hit = reg_space == pc_irq_pkg::space_exca;
  assign cfg_hit = reg_space == pc_irq_pkg::space_config;
  assign skt_hit = reg_space == pc_irq_pkg::space_socket;
  // The second socket's copy sits 40h higher.
  assign exca_sock = reg_addr[`EXCA_SOCKET_BIT];
  assign exca_ofs = {reg_addr[7], 1'b0, reg_addr[5:0]};

  logic [7:0] exca_mask_q [2], exca_fsel_q [2], exca_global_q [2];
  logic [3:0] cb_mask_q [2], exca_flags [2], cb_flags [2];
  logic [3:0] exca_set [2], cb_set [2], csc_sel [2], func_sel [2];
  logic [1:0] func_req, csc_req, csc_out, csc_prev_q, pci_req;
  logic [27:0] mf_route_q;
  logic [7:0] devctl_q;
  logic tie_q;

  // ******************************************************************
  // Per-socket event logic
  // ******************************************************************
  for (genvar s = 0; s < 2; s++) begin : g_sock
    localparam int P = s * `PIN_PER_SOCKET;
    logic is_io, hit_mine, flags_rd, flags_wr, edge_mode;
    logic [3:0] exca_clr, cb_clr;
    assign is_io = !memory_card[s] && !cardbus_card[s];
    assign hit_mine = exca_hit && (exca_sock == 1'(s));
    assign flags_rd = reg_rd && hit_mine && exca_ofs == `EXCA_FLAGS_OFS;
    assign flags_wr = reg_wr && hit_mine && exca_ofs == `EXCA_FLAGS_OFS;

    // Detected events sort into status-change sources only.
    assign exca_set[s][`FLAG_BATT_ONE] =
      (memory_card[s] && pin_toggle[P])
      || (is_io && pin_rise[P]);
    assign exca_set[s][`FLAG_BATT_TWO] =
      memory_card[s] && pin_toggle[P+1];
    assign exca_set[s][`FLAG_READY] =
      memory_card[s] && pin_toggle[P+2];
    assign exca_set[s][`FLAG_POWER] =
      !cardbus_card[s] && power_up_done[s];
    assign cb_set[s][`EVENT_CARD_STATUS_CHANGE_LINE] =
      cardbus_card[s] && pin_rise[P];
    assign cb_set[s][`EVENT_DETECT_ONE] = pin_toggle[P+3];
    assign cb_set[s][`EVENT_DETECT_TWO] = pin_toggle[P+4];
    assign cb_set[s][`EVENT_POWER] =
      cardbus_card[s] && power_up_done[s];

    // The shared request line is a functional source for I/O and
    // CardBus cards only, and no mask can stop it.
    assign func_req[s] = (is_io || cardbus_card[s])
                         && pin_level[P+2];

    // Read-clear is the reset default of the method bit.
    assign exca_clr =
      exca_global_q[s][`GLOBAL_CLEAR_METHOD_BIT]
      ? (flags_wr ? reg_wdata[3:0] : 4'h0)
      : (flags_rd ? 4'hF : 4'h0);
    assign cb_clr = (reg_wr && skt_hit && reg_func == 1'(s)
                     && reg_addr == `SKT_EVENT_OFS)
                    ? reg_wdata[3:0] : 4'h0;

    flag_bank #(.W(4)) u_exca_flags (
      .clk(clk), .nrst(nrst), .clear(exca_clr), .flags(exca_flags[s]),
      .set(exca_set[s] & exca_mask_q[s][3:0])
    );
    flag_bank #(.W(4)) u_cb_flags (
      .clk(clk), .nrst(nrst), .clear(cb_clr), .flags(cb_flags[s]),
      .set(cb_set[s] & cb_mask_q[s])
    );

    assign csc_req[s] = |(exca_flags[s] & exca_mask_q[s][3:0])
                        || |(cb_flags[s] & cb_mask_q[s]);
    assign edge_mode = exca_global_q[s][`GLOBAL_SIGNAL_MODE_BIT];
    // Edge mode gives one pulse per new pending state.
    assign csc_out[s] = edge_mode
                        ? csc_req[s] && !csc_prev_q[s]
                        : csc_req[s];
    assign csc_sel[s] = exca_mask_q[s][7:4];
    assign func_sel[s] = exca_fsel_q[s][3:0];
    // Selector zero sends a class to the socket's PCI interrupt.
    assign pci_req[s] = (csc_sel[s] == 4'h0 && csc_out[s])
                        || (func_sel[s] == 4'h0 && func_req[s]);

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        exca_mask_q[s] <= `RESET_BYTE;
        exca_fsel_q[s] <= `RESET_BYTE;
        exca_global_q[s] <= `RESET_BYTE;
        cb_mask_q[s] <= `RESET_NIBBLE;
        csc_prev_q[s] <= 1'b0;
      end else begin
        csc_prev_q[s] <= csc_req[s];
        if (reg_wr && hit_mine && exca_ofs == `EXCA_MASK_OFS) begin
          exca_mask_q[s] <= reg_wdata[7:0];
        end
        if (reg_wr && hit_mine && exca_ofs == `EXCA_FUNC_SEL_OFS) begin
          exca_fsel_q[s] <= reg_wdata[7:0];
        end
        if (reg_wr && hit_mine && exca_ofs == `EXCA_GLOBAL_OFS) begin
          exca_global_q[s] <= reg_wdata[7:0];
        end
        if (reg_wr && skt_hit && reg_func == 1'(s)
            && reg_addr == `SKT_MASK_OFS) begin
          cb_mask_q[s] <= reg_wdata[3:0];
        end
      end
    end
  end

  // ******************************************************************
  // Shared configuration registers
  // ******************************************************************
  logic cfg_wr;

  assign cfg_wr = reg_wr && cfg_hit;

  // Either function writes the one routing register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tie_q <= 1'b0;
      mf_route_q <= `RESET_ROUTE;
      devctl_q <= `RESET_BYTE;
    end else begin
      if (cfg_wr && reg_addr == `CFG_SYSCTL_OFS) begin
        tie_q <= reg_wdata[`SYSCTL_TIE_BIT];
      end
      if (cfg_wr && reg_addr == `CFG_MFROUTE_OFS) begin
        mf_route_q <= reg_wdata[27:0];
      end
      if (cfg_wr && reg_addr == `CFG_DEVCTL_OFS) begin
        devctl_q <= reg_wdata[7:0];
      end
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  logic [7:0] exca_rd;
  logic [31:0] cfg_rd, skt_rd, rd_d, reg_rdata_q;
  logic reg_rvalid_q;
  assign exca_rd =
    exca_ofs == `EXCA_FLAGS_OFS ? {4'h0, exca_flags[exca_sock]}
    : exca_ofs == `EXCA_MASK_OFS ? exca_mask_q[exca_sock]
    : exca_ofs == `EXCA_FUNC_SEL_OFS ? exca_fsel_q[exca_sock]
    : exca_ofs == `EXCA_GLOBAL_OFS ? exca_global_q[exca_sock]
    : 8'h00;
  assign cfg_rd =
    reg_addr == `CFG_SYSCTL_OFS ? {2'h0, tie_q, 29'h0}
    : reg_addr == `CFG_MFROUTE_OFS ? {4'h0, mf_route_q}
    : reg_addr == `CFG_CARDCTL_OFS ? {31'h0, func_req[reg_func]}
    : reg_addr == `CFG_DEVCTL_OFS ? {24'h0, devctl_q}
    : 32'h0;
  assign skt_rd =
    reg_addr == `SKT_EVENT_OFS ? {28'h0, cb_flags[reg_func]}
    : reg_addr == `SKT_MASK_OFS ? {28'h0, cb_mask_q[reg_func]}
    : 32'h0;
  assign rd_d = exca_hit ? {24'h0, exca_rd}
                : cfg_hit ? cfg_rd
                : skt_hit ? skt_rd
                : 32'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 32'h0;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_d;
      end
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;

  // ******************************************************************
  // Interrupt routing to the terminals
  // ******************************************************************
  logic inta_req, intb_req;
  logic [15:0] irq_vec;
  logic [6:0] mf_out_d, mf_oe_d, mf_out_q, mf_oe_q;
  assign inta_req = pci_req[0] || (tie_q && pci_req[1]);
  assign intb_req = pci_req[1] && !tie_q;
  assign parallel_mode = devctl_q[`DEVCTL_SCHEME_HI:`DEVCTL_SCHEME_LO]
                         == `DEVCTL_SCHEME_PARALLEL;

  for (genvar k = 0; k < 16; k++) begin : g_irq
    assign irq_vec[k] =
      (csc_out[0] && csc_sel[0] == 4'(k))
      || (csc_out[1] && csc_sel[1] == 4'(k))
      || (func_req[0] && func_sel[0] == 4'(k))
      || (func_req[1] && func_sel[1] == 4'(k));
  end

  for (genvar t = 0; t < `MF_COUNT; t++) begin : g_term
    logic [3:0] field;
    logic is_int, is_irq;
    assign field = mf_route_q[t*`MF_FIELD_W +: `MF_FIELD_W];
    assign is_int = t < 2 && field == `MF_CODE_PCI_INT;
    assign is_irq = parallel_mode
                    && field >= `MF_CODE_FIRST_IRQ;
    // PCI interrupts are open drain: drive low only when asserted.
    // Legacy IRQs are driven high-true levels, as the controller
    // expects on its edge or level inputs.
    assign mf_oe_d[t] = is_int
                        ? (t == 0 ? inta_req : intb_req)
                        : is_irq;
    assign mf_out_d[t] = !is_int && is_irq
                         && irq_vec[field];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mf_out_q <= 7'h00;
      mf_oe_q <= 7'h00;
    end else begin
      mf_out_q <= mf_out_d;
      mf_oe_q <= mf_oe_d;
    end
  end

  assign multifunction_terminals_out = mf_out_q;
  assign multifunction_terminals_oe = mf_oe_q;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_battery_flag_set: assert property (
    memory_card[0] && pin_toggle[1] && exca_mask_q[0][1]
    |=> exca_flags[0][1]) else $error("battery flag not set");
  chk_ready_flag_set: assert property (
    memory_card[0] && pin_toggle[2] && exca_mask_q[0][2]
    |=> exca_flags[0][2]) else $error("ready flag not set");
  chk_card_status_change_line_flag_set: assert property (
    !memory_card[0] && !cardbus_card[0] && pin_rise[0]
    && exca_mask_q[0][0] |=> exca_flags[0][0])
    else $error("status change flag not set");
  chk_power_event_set: assert property (
    cardbus_card[1] && power_up_done[1] && cb_mask_q[1][3]
    |=> cb_flags[1][3] && (!exca_flags[1][3] || $past(exca_flags[1][3])))
    else $error("power event misplaced");
  chk_func_status_read: assert property (
    reg_rd && cfg_hit && reg_addr == `CFG_CARDCTL_OFS && !reg_func
    |=> reg_rvalid && reg_rdata[0] == $past(func_req[0]))
    else $error("functional status read wrong");
  chk_memory_no_func: assert property (
    memory_card[0] |-> !func_req[0])
    else $error("memory card raised functional request");
  chk_cb_card_status_change_line_set: assert property (
    cardbus_card[1] && pin_rise[5] && cb_mask_q[1][0]
    |=> cb_flags[1][0]) else $error("cardbus status change not set");
  chk_detect_event_set: assert property (
    pin_toggle[8] && cb_mask_q[1][1] |=> cb_flags[1][1])
    else $error("detect event not set");
  chk_read_clears: assert property (
    reg_rd && exca_hit && !exca_sock && exca_ofs == `EXCA_FLAGS_OFS
    && !exca_global_q[0][`GLOBAL_CLEAR_METHOD_BIT]
    && exca_set[0] == 4'h0 |=> exca_flags[0] == 4'h0)
    else $error("read did not clear flags");
  chk_event_sticky: assert property (
    !(reg_wr && skt_hit && !reg_func && reg_addr == `SKT_EVENT_OFS)
    |=> (cb_flags[0] & $past(cb_flags[0])) == $past(cb_flags[0]))
    else $error("socket event dropped without write");
  chk_tie_route: assert property (
    tie_q && pci_req[1] && mf_route_q[3:0] == `MF_CODE_PCI_INT
    |=> multifunction_terminals_oe[0]
    && !multifunction_terminals_out[0])
    else $error("tied interrupt not on first terminal");
  chk_parallel_gate: assert property (
    !parallel_mode |=> multifunction_terminals_oe[6:2] == 5'h00)
    else $error("legacy IRQ driven without selection");
  chk_edge_pulse: assert property (
    exca_global_q[0][`GLOBAL_SIGNAL_MODE_BIT] && csc_out[0]
    |=> !csc_out[0]) else $error("edge mode pulse longer than one cycle");

  cov_read_clear: cover property (
    exca_flags[0] != 4'h0 ##1 reg_rd && exca_hit
    && exca_ofs == `EXCA_FLAGS_OFS ##1 exca_flags[0] == 4'h0);
  cov_irq_driven: cover property (
    parallel_mode && multifunction_terminals_out[2]);
  cov_tied_inta: cover property (
    tie_q && pci_req[1] ##1 multifunction_terminals_oe[0]);

endmodule : pc_card_irq

// File: tb/card_socket_model.sv
`timescale 1ns/1ps
// ********************************************************************
// Cards in both sockets and the board side of the terminals
// ********************************************************************
module card_socket_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wanted pin levels from the bench
  input wire logic [9:0] want,
  // Socket pins
  output logic [1:0] bd1,
  output logic [1:0] bd2,
  output logic [1:0] req,
  output logic [1:0] cd1,
  output logic [1:0] cd2,
  // Multifunction terminals
  input wire logic [6:0] t_out,
  input wire logic [6:0] t_oe,
  output logic [6:0] t_wire
);
  logic [9:0] pins_q;

  // Card lines move just after an edge; they are registered on clk.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_q <= 10'h000;
    end else begin
      pins_q <= want;
    end
  end

  assign {cd2, cd1, req, bd2, bd1} = pins_q;
  // A released terminal floats up through the board pull-up.
  assign t_wire = (t_oe & t_out) | ~t_oe;
endmodule : card_socket_model

// File: tb/pc_card_irq_tb.sv
`timescale 1ns/1ps
module pc_card_irq_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  pc_irq_pkg::reg_space_type reg_space = pc_irq_pkg::space_exca;
  logic reg_func = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [1:0] bd1, bd2, req, cd1, cd2;
  logic [1:0] memory_card = 2'h1;
  logic [1:0] cardbus_card = 2'h0;
  logic [1:0] power_up_done = 2'h0;
  logic [6:0] t_out, t_oe, t_wire;
  logic [9:0] want = 10'h000;
  logic [7:0] ad [10] = '{8'h04, 8'h05, 8'h1E, 8'h3F, 8'h80, 8'h8C,
                          8'h91, 8'h92, 8'h00, 8'h04};
  logic [3:0] m;
  int mismatches = 0;
  int checks = 0;
  int seed = 32'ha4c583eb;

  always #5 clk = ~clk;

  pc_card_irq i_pc_card_irq (.clk(clk), .nrst(nrst), .reg_space(reg_space),
    .reg_func(reg_func), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .battery_detect_one(bd1),
    .battery_detect_two(bd2), .io_card_request_line(req),
    .card_detect_one(cd1), .card_detect_two(cd2),
    .memory_card(memory_card), .cardbus_card(cardbus_card),
    .power_up_done(power_up_done), .multifunction_terminals_out(t_out),
    .multifunction_terminals_oe(t_oe));

  card_socket_model i_card_socket_model (.clk(clk), .nrst(nrst),
    .want(want), .bd1(bd1), .bd2(bd2), .req(req), .cd1(cd1), .cd2(cd2),
    .t_out(t_out), .t_oe(t_oe), .t_wire(t_wire));

  // ******************************************************************
  // Bus cycles and comparisons
  // ******************************************************************
  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string n, input logic [1:0] e,
                         input logic [1:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin

  // Only events whose mask bit is set may leave a flag behind.
  function automatic logic [31:0] exp_flags(input logic [3:0] mask,
                                            input logic [3:0] ev);
    return {28'h0000000, mask & ev};
  endfunction : exp_flags

  task automatic put(input pc_irq_pkg::reg_space_type s, input logic f,
                     input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    reg_space <= s;
    reg_func <= f;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= ~w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : put

  task automatic wr(input pc_irq_pkg::reg_space_type s, input logic f,
                    input logic [7:0] a, input logic [31:0] d);
    put(s, f, a, 1'b1, d);
  endtask : wr

  // Read data is only trusted in the cycle that reg_rvalid stands.
  task automatic expect_reg(input pc_irq_pkg::reg_space_type s,
                            input logic f, input logic [7:0] a,
                            input logic [31:0] e, input string n);
    put(s, f, a, 1'b0, 32'h00000000);
    #1;
    chk_reg(n, e, (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX);
  endtask : expect_reg

  task automatic expect_term(input int i, input logic [1:0] e);
    #1;
    chk_pin("terminal", e, {t_oe[i], t_wire[i]});
  endtask : expect_term

  // Six edges cover the pin synchroniser, the flag and the output stage.
  task automatic pin(input logic [9:0] x);
    @(posedge clk);
    want <= x;
    repeat (6) @(posedge clk);
  endtask : pin

  task automatic pwr(input logic [1:0] p);
    @(posedge clk);
    power_up_done <= p;
    @(posedge clk);
    power_up_done <= 2'h0;
    repeat (6) @(posedge clk);
  endtask : pwr

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      expect_reg(i < 4 ? pc_irq_pkg::space_exca : i < 8 ?
        pc_irq_pkg::space_config : pc_irq_pkg::space_socket, 1'b0, ad[i],
        32'h00000000, "reset");
    end
    for (int k = 0; k < 4; k++) begin
      m = 4'($random(seed));
      wr(pc_irq_pkg::space_exca, 1'b0, 8'h05, {28'h0000000, m});
      pin(want ^ 10'h015);
      pwr(2'h1);
      expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h04, exp_flags(m, 4'hF),
        "flags");
      expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000000,
        "flags");
    end
    pin(want | 10'h010);
    expect_reg(pc_irq_pkg::space_config, 1'b0, 8'h91, 32'h00000000,
      "func");
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h1E, 32'h00000004);
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h05, 32'h00000004);
    pin(want ^ 10'h010);
    expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000004,
      "flags");
    expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000004,
      "flags");
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000004);
    expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000000,
      "flags");
    expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h45, 32'h00000000,
      "mask");
    // Socket one becomes a CardBus card; its events use the socket registers.
    @(posedge clk);
    memory_card <= 2'h0;
    cardbus_card <= 2'h2;
    wr(pc_irq_pkg::space_socket, 1'b1, 8'h04, 32'h0000000F);
    pin(want ^ 10'h282);
    pwr(2'h2);
    expect_reg(pc_irq_pkg::space_socket, 1'b1, 8'h00, 32'h0000000F,
      "event");
    expect_reg(pc_irq_pkg::space_socket, 1'b1, 8'h00, 32'h0000000F,
      "event");
    wr(pc_irq_pkg::space_socket, 1'b1, 8'h00, 32'h00000001);
    expect_reg(pc_irq_pkg::space_socket, 1'b1, 8'h00, 32'h0000000E,
      "event");
    expect_reg(pc_irq_pkg::space_socket, 1'b0, 8'h00, 32'h00000000,
      "event");
    wr(pc_irq_pkg::space_config, 1'b0, 8'h8C, 32'h0FBA5432);
    expect_reg(pc_irq_pkg::space_config, 1'b1, 8'h8C, 32'h0FBA5432,
      "route");
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h03, 32'h00000003);
    pin(want | 10'h010);
    expect_reg(pc_irq_pkg::space_config, 1'b0, 8'h91, 32'h00000001,
      "func");
    expect_term(1, 2'h1);
    wr(pc_irq_pkg::space_config, 1'b0, 8'h92, 32'h00000004);
    repeat (4) @(posedge clk);
    expect_term(1, 2'h3);
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h05, 32'h00000001);
    pin(want | 10'h001);
    expect_term(0, 2'h2);
    expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000001,
      "flags");
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000001);
    repeat (4) @(posedge clk);
    expect_term(0, 2'h1);
    expect_term(1, 2'h3);
    // Edge mode: the pending state makes one pulse, then lets go.
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h1E, 32'h00000006);
    pin(want & 10'h3FE);
    pin(want | 10'h001);
    expect_term(0, 2'h1);
    expect_reg(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000001,
      "flags");
    wr(pc_irq_pkg::space_exca, 1'b0, 8'h04, 32'h00000001);
    wr(pc_irq_pkg::space_config, 1'b0, 8'h80, 32'h20000000);
    repeat (4) @(posedge clk);
    expect_term(0, 2'h2);
    expect_reg(pc_irq_pkg::space_config, 1'b1, 8'h80, 32'h20000000,
      "tie");
    wr(pc_irq_pkg::space_socket, 1'b1, 8'h00, 32'h0000000F);
    repeat (4) @(posedge clk);
    expect_term(0, 2'h1);
    stop_test();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule : pc_card_irq_tb
